// [logic/bmx_pkg.sv]
// constants and types shared by the block move, search and port execution unit
package bmx_pkg;
	// default clocks per T-state of the divider
	localparam int CYCLES_PER_T_DEF = 1;
	// single-byte opcodes of the immediate-port transfers
	localparam logic [7:0] OP_IN_IMM  = 8'hDB;
	localparam logic [7:0] OP_OUT_IMM = 8'hD3;
	// prefixed groups: 101rd0kk for block ops, 01rrr00x for register-port ops
	localparam logic [2:0] GRP_BLOCK  = 3'h5;
	localparam logic [1:0] GRP_REGIO  = 2'h1;
	localparam logic [2:0] REG_NONE   = 3'h6;
	// flag bit positions
	localparam int FS  = 7;
	localparam int FZ  = 6;
	localparam int FH  = 4;
	localparam int FPV = 2;
	localparam int FN  = 1;
	localparam int FC  = 0;
	// machine cycle lengths in T-states
	localparam logic [2:0] T_FOUR  = 3'h4;
	localparam logic [2:0] T_THREE = 3'h3;
	localparam logic [2:0] T_FIVE  = 3'h5;
	// whole-instruction T-state totals
	localparam logic [4:0] T_SINGLE   = 5'h10;
	localparam logic [4:0] T_REPEAT   = 5'h15;
	localparam logic [4:0] T_PORT_REG = 5'h0C;
	// values after reset
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0]  RST_BYTE = 8'h00;
	// kind of machine cycle
	typedef enum logic [1:0] {K_WAIT, K_RD, K_WR} bmx_kind_e;
	// instruction class
	typedef enum logic [2:0] {C_MOVE, C_CMP, C_BIN, C_BOUT, C_INR, C_OUTR, C_INA, C_OUTA}
		bmx_class_e;
endpackage

// [logic/bmx_exec.sv]
// execution unit for block moves, block searches and port transfers
`timescale 1ns/1ps
`default_nettype none
module bmx_exec #(
	parameter int CYCLES_PER_T = bmx_pkg::CYCLES_PER_T_DEF
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic        opPrefixed,
	input  wire logic [7:0]  opCode,
	input  wire logic [7:0]  immIn,
	input  wire logic [15:0] srcPtrIn,
	input  wire logic [15:0] dstPtrIn,
	input  wire logic [15:0] counterIn,
	input  wire logic [7:0]  accIn,
	input  wire logic [7:0]  flagsIn,
	input  wire logic [7:0]  regIn,
	output logic             ready,
	output logic             done,
	output logic             pcStepBack,
	output logic             refreshPair,
	output logic             intWindow,
	output logic [15:0]      srcPtr,
	output logic [15:0]      dstPtr,
	output logic [15:0]      counter,
	output logic [7:0]       acc,
	output logic [7:0]       flags,
	output logic             regWrite,
	output logic [2:0]       regSel,
	output logic [7:0]       regData,
	output logic             busReq,
	output logic             busWrite,
	output logic             busIo,
	output logic [15:0]      busAddr,
	output logic [7:0]       busWdata,
	input  wire logic        busAck,
	input  wire logic [7:0]  busRdata
);
	typedef enum logic {S_IDLE, S_RUN} bmx_fsm_e;
	typedef struct packed {
		bmx_fsm_e           fsm;
		bmx_pkg::bmx_class_e cls;
		logic               dec;
		logic               rep;
		logic               cont;
		logic [7:0]         div;
		logic [2:0]         phase;
		logic [2:0]         tcnt;
		logic [4:0]         tTot;
		logic               reqOn;
		logic               ackSeen;
		logic               busWrite;
		logic               busIo;
		logic [15:0]        busAddr;
		logic [7:0]         busWdata;
		logic [15:0]        src;
		logic [15:0]        dst;
		logic [15:0]        cnt;
		logic [7:0]         acc;
		logic [7:0]         flags;
		logic [7:0]         imm;
		logic [7:0]         regv;
		logic [2:0]         rSel;
		logic [7:0]         buf0;
		logic [7:0]         buf1;
		logic [1:0]         bufCnt;
		logic               done;
		logic               pcBack;
		logic               refresh;
		logic               intWin;
		logic               regWr;
		logic [7:0]         regData;
	} bmx_state_s;

	bmx_state_s          q;
	bmx_state_s          next_q;
	bmx_pkg::bmx_kind_e  kind;
	logic [2:0]          len;
	logic                tick;
	logic                isBlock;
	logic                bufFull;
	logic                canIssue;
	logic                issued;
	logic                stall;
	logic [15:0]         n16;
	logic [7:0]          n8;
	logic [7:0]          diff;
	logic [15:0]         step;
	logic                decOk;
	bmx_pkg::bmx_class_e decCls;

	// machine cycle lengths per class and index
	function automatic logic [2:0] phaseLen(input bmx_pkg::bmx_class_e c, input logic [2:0] p);
		logic [2:0] r;
		r = bmx_pkg::T_FOUR;
		case (p)
			3'h1: if (c == bmx_pkg::C_BIN || c == bmx_pkg::C_BOUT) begin
				r = bmx_pkg::T_FIVE;
			end else if (c == bmx_pkg::C_INA || c == bmx_pkg::C_OUTA) begin
				r = bmx_pkg::T_THREE;
			end
			3'h2: if (c < bmx_pkg::C_INR) begin
				r = bmx_pkg::T_THREE;
			end
			3'h3: if (c == bmx_pkg::C_MOVE || c == bmx_pkg::C_CMP) begin
				r = bmx_pkg::T_FIVE;
			end
			3'h4: r = bmx_pkg::T_FIVE;
			default: r = bmx_pkg::T_FOUR;
		endcase
		return r;
	endfunction

	// bus activity of each machine cycle
	function automatic bmx_pkg::bmx_kind_e phaseKind(input bmx_pkg::bmx_class_e c,
		input logic [2:0] p);
		bmx_pkg::bmx_kind_e k;
		k = bmx_pkg::K_WAIT;
		if (p == 3'h2) begin
			k = (c == bmx_pkg::C_OUTR || c == bmx_pkg::C_OUTA) ? bmx_pkg::K_WR : bmx_pkg::K_RD;
		end else if (p == 3'h3 && c != bmx_pkg::C_CMP && c < bmx_pkg::C_INR) begin
			k = bmx_pkg::K_WR;
		end
		return k;
	endfunction

	// opcode decode; repeat output forms and the decrementing repeat input are not supported
	always_comb begin
		decOk = 1'b0;
		decCls = bmx_pkg::C_MOVE;
		if (!opPrefixed && opCode == bmx_pkg::OP_IN_IMM) begin
			decOk = 1'b1;
			decCls = bmx_pkg::C_INA;
		end else if (!opPrefixed && opCode == bmx_pkg::OP_OUT_IMM) begin
			decOk = 1'b1;
			decCls = bmx_pkg::C_OUTA;
		end else if (opPrefixed && opCode[7:6] == bmx_pkg::GRP_REGIO && opCode[2:1] == 2'h0) begin
			decOk = 1'b1;
			decCls = opCode[0] ? bmx_pkg::C_OUTR : bmx_pkg::C_INR;
		end else if (opPrefixed && opCode[7:5] == bmx_pkg::GRP_BLOCK && !opCode[2]) begin
			decCls = bmx_pkg::bmx_class_e'({1'b0, opCode[1:0]});
			decOk = !(opCode[4] && (opCode[1] && (opCode[0] || opCode[3])));
		end
	end

	assign kind     = phaseKind(q.cls, q.phase);
	assign len      = phaseLen(q.cls, q.phase);
	assign tick     = (q.div == 8'h00);
	assign isBlock  = (q.cls < bmx_pkg::C_INR);
	assign bufFull  = (q.bufCnt == 2'h2);
	assign canIssue = (kind == bmx_pkg::K_RD) ? !bufFull :
		(q.cls < bmx_pkg::C_INR ? q.bufCnt != 2'h0 : 1'b1);
	assign issued   = q.reqOn || q.ackSeen;
	// an answer sampled in the last T-state ends the machine cycle without a wait
	assign stall    = (kind != bmx_pkg::K_WAIT) && ((q.tcnt == 3'h0 && !issued && !canIssue)
		|| (q.tcnt == len - 3'h1 && !q.ackSeen && !(q.reqOn && busAck)));
	assign n16      = q.cnt - 16'h0001;
	assign n8       = q.cnt[15:8] - 8'h01;
	assign diff     = q.acc - q.buf0;
	assign step     = q.dec ? 16'hFFFF : 16'h0001;

	// next state of the whole unit
	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		next_q.pcBack = 1'b0;
		next_q.refresh = 1'b0;
		next_q.intWin = 1'b0;
		next_q.regWr = 1'b0;
		next_q.div = tick ? 8'(CYCLES_PER_T - 1) : q.div - 8'h01;
		case (q.fsm)
			S_IDLE: if (start && decOk) begin
				next_q.fsm = S_RUN;
				next_q.cls = decCls;
				next_q.dec = opCode[3];
				next_q.rep = opCode[4] && decCls < bmx_pkg::C_INR;
				next_q.div = 8'(CYCLES_PER_T - 1);
				next_q.phase = 3'h0;
				next_q.tcnt = 3'h0;
				next_q.tTot = 5'h00;
				next_q.ackSeen = 1'b0;
				next_q.bufCnt = 2'h0;
				next_q.src = srcPtrIn;
				next_q.dst = dstPtrIn;
				next_q.cnt = counterIn;
				next_q.acc = accIn;
				next_q.flags = flagsIn;
				next_q.imm = immIn;
				next_q.regv = regIn;
				next_q.rSel = opCode[5:3];
			end
			S_RUN: begin
				// bus answer: reads fill the buffer, block writes drain it
				if (q.reqOn && busAck) begin
					next_q.reqOn = 1'b0;
					next_q.ackSeen = 1'b1;
					if (!q.busWrite) begin
						if (q.bufCnt == 2'h0) begin
							next_q.buf0 = busRdata;
						end else begin
							next_q.buf1 = busRdata;
						end
						next_q.bufCnt = q.bufCnt + 2'h1;
					end else if (isBlock) begin
						next_q.buf0 = q.buf1;
						next_q.bufCnt = q.bufCnt - 2'h1;
					end
				end
				if (tick && !stall) begin
					next_q.tTot = q.tTot + 5'h01;
					next_q.tcnt = q.tcnt + 3'h1;
					// bus cycle launch at the first T-state
					if (q.tcnt == 3'h0 && kind != bmx_pkg::K_WAIT) begin
						next_q.reqOn = 1'b1;
						next_q.busWrite = (kind == bmx_pkg::K_WR);
						next_q.busIo = 1'b1;
						next_q.busWdata = q.buf0;
						case (q.cls)
							bmx_pkg::C_MOVE: begin
								next_q.busIo = 1'b0;
								next_q.busAddr = next_q.busWrite ? q.dst : q.src;
							end
							bmx_pkg::C_CMP: begin
								next_q.busIo = 1'b0;
								next_q.busAddr = q.src;
							end
							bmx_pkg::C_BIN: begin
								next_q.busIo = !next_q.busWrite;
								next_q.busAddr = next_q.busWrite ? q.src : q.cnt;
							end
							bmx_pkg::C_BOUT: begin
								next_q.busIo = next_q.busWrite;
								next_q.busAddr = next_q.busWrite ? q.cnt : q.src;
							end
							bmx_pkg::C_INR: next_q.busAddr = q.cnt;
							bmx_pkg::C_OUTR: begin
								next_q.busAddr = q.cnt;
								next_q.busWdata = q.regv;
							end
							bmx_pkg::C_INA: next_q.busAddr = {q.acc, q.imm};
							bmx_pkg::C_OUTA: begin
								next_q.busAddr = {q.acc, q.imm};
								next_q.busWdata = q.acc;
							end
							default: next_q.busAddr = q.src;
						endcase
					end
					// machine cycle end
					if (q.tcnt == len - 3'h1) begin
						next_q.tcnt = 3'h0;
						next_q.ackSeen = 1'b0;
						next_q.phase = q.phase + 3'h1;
						if (isBlock && q.phase == 3'h3) begin
							next_q.src = q.src + step;
							case (q.cls)
								bmx_pkg::C_MOVE: begin
									next_q.dst = q.dst + step;
									next_q.cnt = n16;
									next_q.flags[bmx_pkg::FH] = 1'b0;
									next_q.flags[bmx_pkg::FN] = 1'b0;
									next_q.flags[bmx_pkg::FPV] = !q.rep && n16 != 16'h0000;
									next_q.cont = q.rep && n16 != 16'h0000;
								end
								bmx_pkg::C_CMP: begin
									next_q.cnt = n16;
									next_q.flags[bmx_pkg::FS] = diff[7];
									next_q.flags[bmx_pkg::FZ] = (diff == 8'h00);
									next_q.flags[bmx_pkg::FH] = q.acc[3:0] < q.buf0[3:0];
									next_q.flags[bmx_pkg::FPV] = n16 != 16'h0000;
									next_q.flags[bmx_pkg::FN] = 1'b1;
									next_q.cont = q.rep && n16 != 16'h0000 && diff != 8'h00;
								end
								default: begin
									next_q.cnt[15:8] = n8;
									next_q.flags[bmx_pkg::FZ] = (n8 == 8'h00);
									next_q.flags[bmx_pkg::FN] = 1'b1;
									next_q.cont = q.rep && n8 != 8'h00;
								end
							endcase
							if (!next_q.cont) begin
								next_q.fsm = S_IDLE;
								next_q.done = 1'b1;
								next_q.refresh = q.rep;
								next_q.intWin = q.rep;
							end
						end else if (isBlock && q.phase == 3'h4) begin
							// extra cycle, then refetch of the same instruction
							next_q.fsm = S_IDLE;
							next_q.done = 1'b1;
							next_q.pcBack = 1'b1;
							next_q.refresh = 1'b1;
							next_q.intWin = 1'b1;
						end else if (!isBlock && q.phase == 3'h2) begin
							next_q.fsm = S_IDLE;
							next_q.done = 1'b1;
							next_q.cont = 1'b0;
							if (q.cls == bmx_pkg::C_INA) begin
								next_q.acc = q.buf0;
							end else if (q.cls == bmx_pkg::C_INR) begin
								next_q.regWr = (q.rSel != bmx_pkg::REG_NONE);
								next_q.regData = q.buf0;
								next_q.flags[bmx_pkg::FS] = q.buf0[7];
								next_q.flags[bmx_pkg::FZ] = (q.buf0 == 8'h00);
								next_q.flags[bmx_pkg::FH] = 1'b0;
								next_q.flags[bmx_pkg::FPV] = ~^q.buf0;
								next_q.flags[bmx_pkg::FN] = 1'b0;
							end
						end
					end
				end
			end
			default: next_q.fsm = S_IDLE;
		endcase
	end

	// state register, synchronous reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign ready       = (q.fsm == S_IDLE);
	assign done        = q.done;
	assign pcStepBack  = q.pcBack;
	assign refreshPair = q.refresh;
	assign intWindow   = q.intWin;
	assign srcPtr      = q.src;
	assign dstPtr      = q.dst;
	assign counter     = q.cnt;
	assign acc         = q.acc;
	assign flags       = q.flags;
	assign regWrite    = q.regWr;
	assign regSel      = q.rSel;
	assign regData     = q.regData;
	assign busReq      = q.reqOn;
	assign busWrite    = q.busWrite;
	assign busIo       = q.busIo;
	assign busAddr     = q.busAddr;
	assign busWdata    = q.busWdata;

	// start values kept for checking
	logic [15:0] srcAt;
	logic [15:0] dstAt;
	logic [7:0]  flagsAt;
	always_ff @(posedge clk) begin
		if (ready && start) begin
			srcAt <= srcPtrIn;
			dstAt <= dstPtrIn;
			flagsAt <= flagsIn;
		end
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_move_single_time: assert property (done && q.cls == bmx_pkg::C_MOVE && !q.rep
		|-> q.tTot == bmx_pkg::T_SINGLE) else $error("single move not 16 T-states");
	a_move_dec_ptrs: assert property (done && q.cls == bmx_pkg::C_MOVE && q.dec && !q.rep
		|-> srcPtr == srcAt - 16'h0001 && dstPtr == dstAt - 16'h0001)
		else $error("decrementing move pointers wrong");
	a_move_flag_set: assert property (done && q.cls == bmx_pkg::C_MOVE && !q.rep
		|-> !flags[bmx_pkg::FH] && !flags[bmx_pkg::FN]
		&& flags[bmx_pkg::FPV] == (counter != 16'h0000)
		&& flags[bmx_pkg::FC] == flagsAt[bmx_pkg::FC]) else $error("move flags wrong");
	a_cmp_flag_set: assert property (done && q.cls == bmx_pkg::C_CMP
		|-> flags[bmx_pkg::FN] && flags[bmx_pkg::FC] == flagsAt[bmx_pkg::FC]
		&& flags[bmx_pkg::FZ] == (acc == q.buf0)) else $error("compare flags wrong");
	a_cmp_dec_ptr: assert property (done && q.cls == bmx_pkg::C_CMP
		|-> srcPtr == (q.dec ? srcAt - 16'h0001 : srcAt + 16'h0001))
		else $error("compare pointer step wrong");
	a_rep_cont_time: assert property (pcStepBack |-> q.tTot == bmx_pkg::T_REPEAT)
		else $error("continuing iteration not 21 T-states");
	a_cmp_rep_stop: assert property (done && q.cls == bmx_pkg::C_CMP && q.rep && !pcStepBack
		|-> counter == 16'h0000 || flags[bmx_pkg::FZ]) else $error("search stopped early");
	a_rep_refetch: assert property (done && q.rep && counter != 16'h0000
		&& q.cls == bmx_pkg::C_MOVE |-> pcStepBack) else $error("no refetch");
	a_rep_refresh: assert property (done && q.rep |-> refreshPair && intWindow)
		else $error("no refresh after iteration");
	a_reg_none_wr: assert property (regWrite |-> regSel != bmx_pkg::REG_NONE)
		else $error("register 110 written");
	a_out_reg_time: assert property (done && q.cls == bmx_pkg::C_OUTR
		|-> q.tTot == bmx_pkg::T_PORT_REG && flags == flagsAt)
		else $error("register output timing or flags wrong");
	a_port_blk_zero: assert property (done && (q.cls == bmx_pkg::C_BIN || q.cls == bmx_pkg::C_BOUT)
		|-> flags[bmx_pkg::FZ] == (counter[15:8] == 8'h00) && flags[bmx_pkg::FN]
		&& (q.rep || q.tTot == bmx_pkg::T_SINGLE)) else $error("port block flags wrong");
	a_in_rep_end: assert property (done && q.cls == bmx_pkg::C_BIN && q.rep && !pcStepBack
		|-> counter[15:8] == 8'h00) else $error("input repeat ended early");
	a_bus_hold: assert property (busReq && !busAck |=> busReq && $stable(busAddr))
		else $error("bus request dropped");

	c_move_repeat: cover property (pcStepBack && q.cls == bmx_pkg::C_MOVE);
	c_search_hit: cover property (done && q.cls == bmx_pkg::C_CMP && q.rep
		&& flags[bmx_pkg::FZ] && counter != 16'h0000);
	c_input_repeat: cover property (pcStepBack && q.cls == bmx_pkg::C_BIN);
	c_reg_none: cover property (done && q.cls == bmx_pkg::C_INR && q.rSel == bmx_pkg::REG_NONE);
endmodule
`default_nettype wire

// [tb/bmx_mem_io_model.sv]
// memory and port devices on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module bmx_mem_io_model (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  ackDelay,
	input  wire logic        busReq,
	input  wire logic        busWrite,
	input  wire logic        busIo,
	input  wire logic [15:0] busAddr,
	input  wire logic [7:0]  busWdata,
	output logic             busAck,
	output logic [7:0]       busRdata
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  io [0:255];
	logic [7:0]  waitCnt;
	logic [7:0]  lastData;
	logic [15:0] lastAddr;
	// port n answers n times 25h
	initial begin
		for (int i = 0; i < 256; i++) io[i] = 8'(i * 37);
	end
	// answer after ackDelay cycles; read data toggles while not valid
	always @(posedge clk) begin
		if (!reset_n) begin
			busAck <= 1'b0;
			waitCnt <= 8'h00;
			busRdata <= 8'hA5;
		end else if (busReq && !busAck && waitCnt < ackDelay) begin
			waitCnt <= waitCnt + 8'h01;
			busRdata <= ~busRdata;
		end else if (busReq && !busAck) begin
			busAck <= 1'b1;
			waitCnt <= 8'h00;
			lastAddr <= busAddr;
			lastData <= busWrite ? busWdata : (busIo ? io[busAddr[7:0]] : mem[busAddr]);
			busRdata <= busIo ? io[busAddr[7:0]] : mem[busAddr];
			if (busWrite && !busIo) mem[busAddr] <= busWdata;
		end else begin
			busAck <= 1'b0;
			busRdata <= ~busRdata;
		end
	end
endmodule
`default_nettype wire

// [tb/block_move_search_io_exec_tb.sv]
// self-checking bench of the block move, search and port unit
`timescale 1ns/1ps
`default_nettype none
module block_move_search_io_exec_tb;
	logic        clk, reset_n, start, pre, ready, done, pcStepBack, refreshPair, intWindow;
	logic        regWrite, busReq, busWrite, busIo, busAck;
	logic [7:0]  op, imm, acc, flg, rg, ackDelay, accOut, flags, regData, busWdata, busRdata;
	logic [15:0] src, dst, cnt, srcPtr, dstPtr, counter, busAddr;
	logic [2:0]  regSel;
	int          error_cnt, num_checks, n, it;

	bmx_exec #(.CYCLES_PER_T(1)) dut (.clk(clk), .reset_n(reset_n), .start(start),
		.opPrefixed(pre), .opCode(op), .immIn(imm), .srcPtrIn(src), .dstPtrIn(dst),
		.counterIn(cnt), .accIn(acc), .flagsIn(flg), .regIn(rg), .ready(ready), .done(done),
		.pcStepBack(pcStepBack), .refreshPair(refreshPair), .intWindow(intWindow),
		.srcPtr(srcPtr), .dstPtr(dstPtr), .counter(counter), .acc(accOut), .flags(flags),
		.regWrite(regWrite), .regSel(regSel), .regData(regData), .busReq(busReq),
		.busWrite(busWrite), .busIo(busIo), .busAddr(busAddr), .busWdata(busWdata),
		.busAck(busAck), .busRdata(busRdata));
	bmx_mem_io_model model (.clk(clk), .reset_n(reset_n), .ackDelay(ackDelay),
		.busReq(busReq), .busWrite(busWrite), .busIo(busIo), .busAddr(busAddr),
		.busWdata(busWdata), .busAck(busAck), .busRdata(busRdata));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// compare and count
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// issue one instruction, count cycles to done; fb feeds results back
	task run(input logic p, input logic [7:0] o, input logic fb);
		@(negedge clk);
		pre = p;
		op = o;
		start = 1'b1;
		if (fb) begin
			src = srcPtr;
			dst = dstPtr;
			cnt = counter;
			flg = flags;
		end
		@(negedge clk);
		start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 600) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("ready", ready, 16'h1);
	endtask

	// restart while the unit steps the program counter back
	task rep(input logic [7:0] o);
		it = 0;
		do begin
			run(1'b1, o, it > 0);
			it++;
			chk("T", n, pcStepBack === 1'b1 ? 16'h15 : 16'h10);
			chk("refresh", {refreshPair, intWindow}, 16'h3);
		end while (pcStepBack === 1'b1 && it < 300);
	endtask

	// single moves, the last with slow bus answers
	task t_move();
		for (int k = 0; k < 3; k++) begin
			@(negedge clk);
			src = 16'h1010;
			dst = 16'h2020;
			cnt = (k == 1) ? 16'h0000 : 16'h0001 + 16'(k);
			flg = (k == 0) ? 8'hFF : 8'h00;
			ackDelay = (k == 2) ? 8'h02 : 8'h00;
			model.mem[src] = 8'h3C + 8'(k);
			run(1'b1, (k == 1) ? 8'hA8 : 8'hA0, 1'b0);
			// a late read answer adds its delay; the write cycle absorbs up to two
			chk("T", n, 16'h10 + 16'(ackDelay));
			chk("copy", model.mem[dst], 8'h3C + 8'(k));
			chk("srcPtr", srcPtr, (k == 1) ? 16'h100F : 16'h1011);
			chk("dstPtr", dstPtr, (k == 1) ? 16'h201F : 16'h2021);
			chk("counter", counter, cnt - 16'h1);
			chk("f", flags & 8'hD7, flg & 8'hC1 | (cnt != 16'h1 ? 8'h04 : 8'h00));
		end
		ackDelay = 8'h00;
	endtask

	// single compares: equal, borrow, negative, plain
	task automatic t_cmp();
		logic [15:0] tbl [4] = '{16'h4242, 16'h1021, 16'hF00F, 16'h3512};
		logic [7:0]  r;
		for (int k = 0; k < 4; k++) begin
			@(negedge clk);
			src = 16'h3000;
			acc = tbl[k][15:8];
			model.mem[src] = tbl[k][7:0];
			cnt = k[0] ? 16'h0007 : 16'h0001;
			flg = k[0] ? 8'hFF : 8'h00;
			run(1'b1, k[0] ? 8'hA9 : 8'hA1, 1'b0);
			r = acc - tbl[k][7:0];
			chk("T", n, 16'h10);
			chk("srcPtr", srcPtr, k[0] ? 16'h2FFF : 16'h3001);
			chk("counter", counter, cnt - 16'h1);
			r = {r[7], r == 8'h00, 1'b0, acc[3:0] < tbl[k][3:0], 1'b0, k[0], 1'b1, k[0]};
			chk("f", flags & 8'hD7, r);
		end
	endtask

	// repeating moves up and down
	task t_mrep();
		for (int k = 0; k < 2; k++) begin
			@(negedge clk);
			src = 16'h6010;
			dst = 16'h7010;
			cnt = 16'h0003 - 16'(k);
			flg = 8'hFF;
			for (int i = 0; i < 3; i++) model.mem[k ? src - 16'(i) : src + 16'(i)] = 8'hC0 + 8'(i);
			rep(k ? 8'hB8 : 8'hB0);
			chk("iters", it, 3 - k);
			chk("dstPtr", dstPtr, k ? 16'h700E : 16'h7013);
			chk("copy", model.mem[k ? 16'h700F : 16'h7012], k ? 8'hC1 : 8'hC2);
			chk("f", flags & 8'hD7, 8'hC1);
		end
	endtask

	// repeating compares: stop on a match, run out without one
	task t_crep();
		@(negedge clk);
		src = 16'h8000;
		cnt = 16'h0005;
		acc = 8'h33;
		for (int i = 0; i < 5; i++) model.mem[16'h8000 + 16'(i)] = 8'h11 * 8'(i + 1);
		rep(8'hB1);
		chk("iters", it, 3);
		chk("srcPtr", srcPtr, 16'h8003);
		chk("f", flags & 8'h46, 8'h46);
		@(negedge clk);
		src = 16'h8001;
		cnt = 16'h0002;
		acc = 8'h99;
		rep(8'hB9);
		chk("iters", it, 2);
		chk("srcPtr", srcPtr, 16'h7FFF);
		chk("f", flags & 8'h46, 8'h02);
	endtask

	// immediate and register port transfers
	task automatic t_port();
		logic [7:0] d;
		@(negedge clk);
		acc = 8'h12;
		imm = 8'h34;
		run(1'b0, 8'hDB, 1'b0);
		chk("T", n, 16'h0B);
		chk("a", accOut, 8'h84);
		chk("port", model.lastAddr, 16'h1234);
		run(1'b0, 8'hD3, 1'b0);
		chk("T", n, 16'h0B);
		chk("out", model.lastData, 8'h12);
		chk("port", model.lastAddr, 16'h1234);
		for (int r = 0; r < 8; r++) begin
			@(negedge clk);
			cnt = {8'h03, 8'(r)};
			flg = {8{r[0]}};
			rg = 8'hA0 + 8'(r);
			d = 8'(r * 37);
			run(1'b1, {2'h1, 3'(r), 3'h0}, 1'b0);
			chk("we", regWrite, r != 6);
			if (r != 6) chk("reg", {regSel, regData}, {3'(r), d});
			chk("f", flags & 8'hD7, {d[7], d == 8'h00, 3'h0, ~^d, 1'b0, r[0]});
			run(1'b1, {2'h1, 3'(r), 3'h1}, 1'b0);
			chk("T", n, 16'h0C);
			chk("port", model.lastAddr, cnt);
			chk("out", model.lastData, rg);
			chk("f", flags & 8'hD7, flg & 8'hD7);
		end
	endtask

	// single block port transfers at counter boundaries
	task automatic t_blk();
		logic [7:0] ops [4] = '{8'hA2, 8'hAA, 8'hA3, 8'hAB};
		logic [7:0] b;
		for (int k = 0; k < 4; k++) begin
			@(negedge clk);
			b = (k == 0 || k == 3) ? 8'h01 : 8'h02;
			src = 16'h4000 + 16'(k * 16);
			cnt = {b, 8'h05 + 8'(k)};
			flg = 8'hFF;
			model.mem[src] = 8'h70 + 8'(k);
			run(1'b1, ops[k], 1'b0);
			chk("T", n, 16'h10);
			chk("srcPtr", srcPtr, ops[k][3] ? src - 16'h1 : src + 16'h1);
			chk("counter", counter, cnt - 16'h0100);
			chk("f", flags & 8'h43, b == 8'h01 ? 8'h43 : 8'h03);
			if (ops[k][0]) chk("out", model.lastData, 8'h70 + 8'(k));
			else chk("in", model.mem[src], 8'(cnt[7:0] * 8'h25));
		end
	endtask

	// repeating port input from a zero counter
	task t_port_in_repeat_inc();
		@(negedge clk);
		src = 16'h5000;
		cnt = 16'h0009;
		rep(8'hB2);
		chk("iters", it, 256);
		chk("counter", counter, 16'h0009);
		chk("srcPtr", srcPtr, 16'h5100);
		chk("tail", model.mem[16'h50FF], 8'h4D);
		chk("z", flags & 8'h40, 8'h40);
	endtask

	// counts and verdict, then stop
	task summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// reset, scenarios, verdict
	initial begin
		{start, pre, op, imm, acc, flg, rg, src, dst, cnt, ackDelay} = '0;
		reset_n = 1'b0;
		repeat (10) @(negedge clk);
		chk("rst", {ready, done, busReq}, 16'h4);
		reset_n = 1'b1;
		t_move();
		t_cmp();
		t_mrep();
		t_crep();
		t_port();
		t_blk();
		t_port_in_repeat_inc();
		summarize();
	end

	// hang guard, well beyond the expected run
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		summarize();
	end
endmodule
`default_nettype wire
